// *** vector_map.sv ***
/*
  Reset and interrupt vector map: reset fetch address, vector dispatch to
  the core, vector table relocation with a timed unlock, APB registers and
  one interrupt line. Assumes request lines, fuse level, boot address and
  core handshakes are synchronous to clk; nrst covers every reset cause.
*/
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module vector_map
  import vector_map_pkg::*;
#(
  parameter int SRC_N = vector_map_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               nrst,
  // Configuration levels
  input  wire logic                               boot_reset_select_fuse,
  input  wire logic [vector_map_pkg::ADDR_W-1:0]  boot_reset_addr,
  // Peripheral requests, bit 0 is vector 2
  input  wire logic [SRC_N-1:0]                   irq_lines,
  // Core fetch and acceptance
  input  wire logic                               global_int_enable,
  input  wire logic                               irq_ack,
  input  wire logic                               insn_done,
  output logic                                    reset_fetch,
  output logic [vector_map_pkg::ADDR_W-1:0]       reset_addr,
  output logic                                    irq_valid,
  output logic [vector_map_pkg::NUM_W-1:0]        irq_num,
  output logic [vector_map_pkg::ADDR_W-1:0]       irq_addr,
  output logic                                    accept_blocked,
  // APB slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [vector_map_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Interrupt to the system
  output logic                                    intr
);
  import vector_map_pkg::*;

  typedef struct packed {
    logic              started;
    logic              fuse_prog;
    logic [ADDR_W-1:0] boot_base;
    logic              rst_fetch;
    logic [ADDR_W-1:0] rst_addr;
    logic              sel;
    logic              unlock;
    logic [2:0]        unlock_cnt;
    logic              wait_insn;
    logic              blocked;
    logic              irq_valid;
    logic [NUM_W-1:0]  irq_num;
    logic [ADDR_W-1:0] irq_addr;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic              intr;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  vec_if vif (
    .clk  (clk),
    .nrst (nrst)
  );

  vector_calc u_vector_calc (
    .v (vif.calc)
  );

  function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
    reg_mapped = (a == REG_CTRL) || (a == REG_STATUS) ||
                 (a == REG_MASK) || (a == REG_STATE);
  endfunction : reg_mapped

  function automatic logic [31:0] reg_read(input state_t s,
                                            input logic [APB_AW-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      REG_CTRL: begin
        w[CTRL_SELECT_BIT] = s.sel;
        w[CTRL_UNLOCK_BIT] = s.unlock;
      end
      REG_STATUS: w[EV_W-1:0] = s.status;
      REG_MASK:   w[EV_W-1:0] = s.mask;
      REG_STATE: begin
        w[ST_SELECT]                    = s.sel;
        w[ST_FUSE_PROG]                 = s.fuse_prog;
        w[ST_UNLOCK]                    = s.unlock;
        w[ST_BLOCKED]                   = s.blocked;
        w[ST_IRQ_VALID]                 = s.irq_valid;
        w[ST_NUM_LSB+NUM_W-1:ST_NUM_LSB] = s.irq_num;
      end
      default: w = 32'h0000_0000;
    endcase
    reg_read = w;
  endfunction : reg_read

  // Active table base for interrupt vectors
  assign vif.pending = irq_lines;
  assign vif.base    = s_r.sel ? s_r.boot_base : OFF_RESET;

  always_comb begin
    logic            access;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    s_nxt     = s_r;
    access    = psel && penable && s_r.pready;
    ev        = '0;
    clr       = '0;
    s_nxt.rst_fetch = 1'b0;

    // Capture fuse and boot address once after reset release
    if (!s_r.started) begin
      s_nxt.started   = 1'b1;
      s_nxt.fuse_prog = (boot_reset_select_fuse == FUSE_PROGRAMMED);
      s_nxt.boot_base = boot_reset_addr;
      s_nxt.rst_fetch = 1'b1;
      if (boot_reset_select_fuse == FUSE_PROGRAMMED) begin
        s_nxt.rst_addr = boot_reset_addr;
      end else begin
        s_nxt.rst_addr = OFF_RESET;
      end
    end

    // Unlock window countdown
    if (s_r.unlock) begin
      if (s_r.unlock_cnt == 3'h1) begin
        s_nxt.unlock     = 1'b0;
        s_nxt.unlock_cnt = 3'h0;
        ev[EV_UNLOCK_LAPSED] = 1'b1;
      end else begin
        s_nxt.unlock_cnt = s_r.unlock_cnt - 3'h1;
      end
    end

    // Block lasts until the instruction after the select write retires
    if (s_r.wait_insn && insn_done) begin
      s_nxt.wait_insn = 1'b0;
    end

    // APB setup phase prepares the answer
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !reg_mapped(paddr);
      s_nxt.prdata  = pwrite ? 32'h0000_0000 : reg_read(s_r, paddr);
    end

    // APB access phase commits
    if (access && pwrite) begin
      case (paddr)
        REG_CTRL: begin
          if (pwdata[CTRL_UNLOCK_BIT]) begin
            s_nxt.unlock     = 1'b1;
            s_nxt.unlock_cnt = UNLOCK_CYCLES;
            ev[EV_UNLOCK_LAPSED] = 1'b0;
          end else if (s_r.unlock) begin
            s_nxt.sel        = pwdata[CTRL_SELECT_BIT];
            s_nxt.unlock     = 1'b0;
            s_nxt.unlock_cnt = 3'h0;
            s_nxt.wait_insn  = 1'b1;
            ev[EV_SELECT_DONE]   = 1'b1;
            ev[EV_UNLOCK_LAPSED] = 1'b0;
          end
        end
        REG_MASK: s_nxt.mask = pwdata[EV_W-1:0];
        default: ;
      endcase
    end

    // Read clears only the bits that the read returned
    if (access && !pwrite && paddr == REG_STATUS) begin
      clr = s_r.prdata[EV_W-1:0];
    end
    s_nxt.status = (s_r.status & ~clr) | ev;
    s_nxt.intr   = |(s_nxt.status & s_nxt.mask);

    s_nxt.blocked = s_nxt.unlock || s_nxt.wait_insn;

    // Dispatch towards the core
    if (s_r.irq_valid) begin
      if (irq_ack) begin
        s_nxt.irq_valid = 1'b0;
      end
    end else if (s_r.started && !s_r.blocked && global_int_enable && vif.valid) begin
      s_nxt.irq_valid = 1'b1;
      s_nxt.irq_num   = vif.num;
      s_nxt.irq_addr  = vif.addr;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{started:    1'b0,
               fuse_prog:  1'b0,
               boot_base:  OFF_RESET,
               rst_fetch:  1'b0,
               rst_addr:   OFF_RESET,
               sel:        SELECT_RESET,
               unlock:     1'b0,
               unlock_cnt: 3'h0,
               wait_insn:  1'b0,
               blocked:    1'b0,
               irq_valid:  1'b0,
               irq_num:    VEC_RESET,
               irq_addr:   OFF_RESET,
               status:     2'h0,
               mask:       MASK_RESET,
               intr:       1'b0,
               pready:     1'b0,
               pslverr:    1'b0,
               prdata:     32'h0000_0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reset_fetch    = s_r.rst_fetch;
  assign reset_addr     = s_r.rst_addr;
  assign irq_valid      = s_r.irq_valid;
  assign irq_num        = s_r.irq_num;
  assign irq_addr       = s_r.irq_addr;
  assign accept_blocked = s_r.blocked;
  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign intr           = s_r.intr;

  a_reset_fetch_addr: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s_r.started) |-> s_r.rst_fetch &&
      s_r.rst_addr == (s_r.fuse_prog ? s_r.boot_base : OFF_RESET))
    else $error("reset fetch address does not follow the fuse");

  a_fuse_decode: assert property (@(posedge clk) disable iff (!nrst)
    !s_r.started |=> s_r.fuse_prog == ($past(boot_reset_select_fuse) == 1'b0))
    else $error("fuse value decoded the wrong way round");

  a_unprog_reset_zero: assert property (@(posedge clk) disable iff (!nrst)
    s_r.rst_fetch && !s_r.fuse_prog |-> s_r.rst_addr == 16'h0000)
    else $error("unrelocated reset not at word zero");

  a_table_base: assert property (@(posedge clk) disable iff (!nrst)
    s_r.started |-> vif.base == (s_r.sel ? s_r.boot_base : 16'h0000))
    else $error("interrupt table base disagrees with select bit");

  a_unlock_lapse: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s_r.unlock) |-> ##[1:4] !s_r.unlock)
    else $error("unlock bit outlived its four-cycle window");

  a_unlock_on_select: assert property (@(posedge clk) disable iff (!nrst)
    psel && penable && s_r.pready && pwrite && paddr == REG_CTRL &&
      !pwdata[CTRL_UNLOCK_BIT] && s_r.unlock
    |=> !s_r.unlock && s_r.wait_insn && s_r.sel == $past(pwdata[CTRL_SELECT_BIT]))
    else $error("select write did not end the unlock window");

  a_select_locked: assert property (@(posedge clk) disable iff (!nrst)
    !s_r.unlock |=> s_r.sel == $past(s_r.sel))
    else $error("select bit changed without unlock");

  a_no_accept_blocked: assert property (@(posedge clk) disable iff (!nrst)
    s_r.blocked && !s_r.irq_valid |=> !s_r.irq_valid)
    else $error("interrupt accepted while blocked");

  a_block_four: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s_r.unlock) |-> s_r.blocked [*4])
    else $error("block ended before four cycles");

  a_intr_level: assert property (@(posedge clk) disable iff (!nrst)
    s_r.intr == |(s_r.status & s_r.mask))
    else $error("interrupt line disagrees with status and mask");

  a_setup_ready: assert property (@(posedge clk) disable iff (!nrst)
    psel && !penable |=> s_r.pready)
    else $error("no answer in the cycle after setup");

  a_ready_single: assert property (@(posedge clk) disable iff (!nrst)
    s_r.pready |=> !s_r.pready)
    else $error("ready stood longer than one cycle");

  a_refused_addr: assert property (@(posedge clk) disable iff (!nrst)
    psel && !penable && paddr != REG_CTRL && paddr != REG_STATUS &&
      paddr != REG_MASK && paddr != REG_STATE
    |=> s_r.pslverr && s_r.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_mask_write: assert property (@(posedge clk) disable iff (!nrst)
    psel && penable && s_r.pready && pwrite && paddr == REG_MASK
    |=> s_r.mask == $past(pwdata[EV_W-1:0]))
    else $error("mask write did not land");

  a_lapse_event: assert property (@(posedge clk) disable iff (!nrst)
    $fell(s_r.unlock) && !s_r.wait_insn |-> s_r.status[EV_UNLOCK_LAPSED])
    else $error("lapsed unlock left no status event");

  a_unlock_count: assert property (@(posedge clk) disable iff (!nrst)
    s_r.unlock |-> s_r.unlock_cnt != 3'h0 && s_r.unlock_cnt <= UNLOCK_CYCLES)
    else $error("unlock counter outside its window");

  a_block_release: assert property (@(posedge clk) disable iff (!nrst)
    s_r.wait_insn && !s_r.unlock && insn_done |=> !s_r.wait_insn)
    else $error("block outlived the instruction after the select write");

  a_offer_hold: assert property (@(posedge clk) disable iff (!nrst)
    s_r.irq_valid && !irq_ack
    |=> s_r.irq_valid && $stable(s_r.irq_num) && $stable(s_r.irq_addr))
    else $error("offered vector changed before acceptance");

  a_offer_drop: assert property (@(posedge clk) disable iff (!nrst)
    s_r.irq_valid && irq_ack |=> !s_r.irq_valid)
    else $error("offer stayed up after acceptance");

  a_offer_rise: assert property (@(posedge clk) disable iff (!nrst)
    s_r.started && !s_r.irq_valid && !s_r.blocked && global_int_enable && (|irq_lines)
    |=> s_r.irq_valid)
    else $error("free request was not offered");

  a_fetch_pulse: assert property (@(posedge clk) disable iff (!nrst)
    s_r.rst_fetch |=> !s_r.rst_fetch)
    else $error("reset fetch pulse longer than one cycle");

  a_status_sticky: assert property (@(posedge clk) disable iff (!nrst)
    !(psel && penable && s_r.pready && !pwrite && paddr == REG_STATUS)
    |=> (s_r.status & $past(s_r.status)) == $past(s_r.status))
    else $error("status bit cleared without a status read");

endmodule : vector_map

// *** vector_map_pkg.sv ***
/*
  Shared constants for the reset and interrupt vector map: vector table,
  register offsets, field positions, reset values and timing counts.
  Assumes word-addressed program memory and a 32-bit APB register bus.
*/
package vector_map_pkg;

  // Program address and vector numbering
  localparam int              ADDR_W        = 16;
  localparam int              NUM_W         = 5;
  localparam int              NUM_SRC       = 21;
  localparam logic [4:0]      VEC_RESET     = 5'h01;
  localparam logic [4:0]      VEC_FIRST_IRQ = 5'h02;

  // Vector table, word offsets from the active base
  localparam logic [15:0] OFF_RESET        = 16'h0000;
  localparam logic [15:0] OFF_EXT_REQ0     = 16'h0002;
  localparam logic [15:0] OFF_PIN_CHG0     = 16'h0004;
  localparam logic [15:0] OFF_PIN_CHG1     = 16'h0006;
  localparam logic [15:0] OFF_T2_COMP      = 16'h0008;
  localparam logic [15:0] OFF_T2_OVF       = 16'h000a;
  localparam logic [15:0] OFF_T1_CAPT      = 16'h000c;
  localparam logic [15:0] OFF_T1_COMPA     = 16'h000e;
  localparam logic [15:0] OFF_T1_COMPB     = 16'h0010;
  localparam logic [15:0] OFF_T1_OVF       = 16'h0012;
  localparam logic [15:0] OFF_T0_COMP      = 16'h0014;
  localparam logic [15:0] OFF_T0_OVF       = 16'h0016;
  localparam logic [15:0] OFF_SPI_DONE     = 16'h0018;
  localparam logic [15:0] OFF_UART_RX      = 16'h001a;
  localparam logic [15:0] OFF_UART_EMPTY   = 16'h001c;
  localparam logic [15:0] OFF_UART_TX      = 16'h001e;
  localparam logic [15:0] OFF_USU_START    = 16'h0020;
  localparam logic [15:0] OFF_USU_OVF      = 16'h0022;
  localparam logic [15:0] OFF_ANA_COMP     = 16'h0024;
  localparam logic [15:0] OFF_ADC_DONE     = 16'h0026;
  localparam logic [15:0] OFF_EEPROM_READY = 16'h0028;
  localparam logic [15:0] OFF_PROG_READY   = 16'h002a;

  // Boot reset fuse encoding
  localparam logic        FUSE_PROGRAMMED  = 1'b0;

  // APB register offsets
  localparam int          APB_AW           = 8;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_MASK         = 8'h08;
  localparam logic [7:0]  REG_STATE        = 8'h0c;

  // Control register fields
  localparam int          CTRL_UNLOCK_BIT  = 0;
  localparam int          CTRL_SELECT_BIT  = 1;
  localparam logic        SELECT_RESET     = 1'b0;

  // Status and mask fields
  localparam int          EV_W             = 2;
  localparam int          EV_SELECT_DONE   = 0;
  localparam int          EV_UNLOCK_LAPSED = 1;
  localparam logic [1:0]  MASK_RESET       = 2'h0;

  // State register fields
  localparam int          ST_SELECT        = 0;
  localparam int          ST_FUSE_PROG     = 1;
  localparam int          ST_UNLOCK        = 2;
  localparam int          ST_BLOCKED       = 3;
  localparam int          ST_IRQ_VALID     = 4;
  localparam int          ST_NUM_LSB       = 8;

  // Unlock window in core cycles
  localparam logic [2:0]  UNLOCK_CYCLES    = 3'h4;

  // Word offset of a vector from its table base
  function automatic logic [15:0] vec_word_offset(input logic [4:0] num);
    vec_word_offset = {10'h000, num - 5'h01, 1'b0};
  endfunction : vec_word_offset

endpackage : vector_map_pkg

// *** vec_if.sv ***
/*
  Carrier between the vector map top and its vector selector.
  Assumes both ends run on the same core clock and reset.
*/
`timescale 1ns/10ps
interface vec_if (
  input wire logic clk,
  input wire logic nrst
);
  import vector_map_pkg::*;

  logic [NUM_SRC-1:0] pending;
  logic [ADDR_W-1:0]  base;
  logic               valid;
  logic [NUM_W-1:0]   num;
  logic [ADDR_W-1:0]  addr;

  modport calc (input clk, input nrst, input pending, input base,
                output valid, output num, output addr);
  modport user (input valid, input num, input addr,
                output pending, output base);
endinterface : vec_if

// *** vector_calc.sv ***
/*
  Picks the lowest-numbered pending request and gives its vector number
  and program address. Assumes request lines are already gated by the
  peripherals' own enables and are synchronous to the core clock.
*/
`timescale 1ns/10ps
module vector_calc (
  // Selector side of the carrier
  vec_if.calc v
);
  import vector_map_pkg::*;

  logic [NUM_W-1:0]  num;
  logic              found;
  logic [ADDR_W-1:0] off;

  // Descending scan so the lowest index is written last
  always_comb begin
    num   = VEC_RESET;
    found = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v.pending[i]) begin
        found = 1'b1;
        num   = NUM_W'(i + 2);
      end
    end
  end

  // Table lookup
  always_comb begin
    case (num)
      5'h02:   off = OFF_EXT_REQ0;
      5'h03:   off = OFF_PIN_CHG0;
      5'h04:   off = OFF_PIN_CHG1;
      5'h05:   off = OFF_T2_COMP;
      5'h06:   off = OFF_T2_OVF;
      5'h07:   off = OFF_T1_CAPT;
      5'h08:   off = OFF_T1_COMPA;
      5'h09:   off = OFF_T1_COMPB;
      5'h0a:   off = OFF_T1_OVF;
      5'h0b:   off = OFF_T0_COMP;
      5'h0c:   off = OFF_T0_OVF;
      5'h0d:   off = OFF_SPI_DONE;
      5'h0e:   off = OFF_UART_RX;
      5'h0f:   off = OFF_UART_EMPTY;
      5'h10:   off = OFF_UART_TX;
      5'h11:   off = OFF_USU_START;
      5'h12:   off = OFF_USU_OVF;
      5'h13:   off = OFF_ANA_COMP;
      5'h14:   off = OFF_ADC_DONE;
      5'h15:   off = OFF_EEPROM_READY;
      5'h16:   off = OFF_PROG_READY;
      default: off = OFF_RESET;
    endcase
  end

  assign v.valid = found;
  assign v.num   = num;
  assign v.addr  = v.base + off;

  a_vector_formula: assert property (@(posedge v.clk) disable iff (!v.nrst)
    v.valid |-> v.addr == v.base + vec_word_offset(v.num))
    else $error("vector address off the two-word grid");

  a_lowest_first: assert property (@(posedge v.clk) disable iff (!v.nrst)
    v.valid |-> (v.pending & ((NUM_SRC'(1) << (v.num - VEC_FIRST_IRQ)) - NUM_SRC'(1))) == '0)
    else $error("a lower-numbered request was passed over");

endmodule : vector_calc

// *** core_model.sv ***
/*
  Behavioural model of the core's fetch and acceptance side: takes each
  offered vector after a bench-set wait and retires instructions on request.
  Assumes the vector map's clock and reset.
*/
`timescale 1ns/10ps
module core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Offer from the vector map
  input  wire logic       irq_valid,
  // Pacing from the bench
  input  wire logic [3:0] ack_wait,
  input  wire logic       insn_go,
  // Acceptance and retire pulses
  output logic            irq_ack,
  output logic            insn_done
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r     <= 4'h0;
      irq_ack   <= 1'b0;
      insn_done <= 1'b0;
    end else begin
      insn_done <= insn_go & ~insn_done;
      irq_ack   <= 1'b0;
      // Only offered vectors are taken; unused slots are never fetched
      if (irq_valid && !irq_ack) begin
        if (cnt_r == ack_wait) begin
          irq_ack <= 1'b1;
          cnt_r   <= 4'h0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule : core_model

// *** vector_map_test.sv ***
/*
  Self-checking bench for the vector map: reset fetch, vector sweep,
  priority, relocation, interrupt status and refused APB accesses.
  Assumes the package, carrier, design and core model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module vector_map_test;
  import vector_map_pkg::*;

  localparam logic [15:0] BOOT = 16'h1c00;
  logic        clk, nrst, fuse, gie, irq_ack, insn_done, insn_go, reset_fetch;
  logic        irq_valid, accept_blocked, psel, penable, pwrite, pready, pslverr;
  logic        intr, err;
  logic [3:0]  ack_wait;
  logic [4:0]  irq_num;
  logic [7:0]  paddr;
  logic [15:0] reset_addr, irq_addr;
  logic [20:0] irq_lines;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, tests_run;

  vector_map u_vector_map (.clk(clk), .nrst(nrst), .boot_reset_select_fuse(fuse),
    .boot_reset_addr(BOOT), .irq_lines(irq_lines), .global_int_enable(gie),
    .irq_ack(irq_ack), .insn_done(insn_done), .reset_fetch(reset_fetch),
    .reset_addr(reset_addr), .irq_valid(irq_valid), .irq_num(irq_num),
    .irq_addr(irq_addr), .accept_blocked(accept_blocked), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .intr(intr));

  core_model u_core_model (.clk(clk), .nrst(nrst), .irq_valid(irq_valid),
    .ack_wait(ack_wait), .insn_go(insn_go), .irq_ack(irq_ack), .insn_done(insn_done));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic hang(input string nm);
    num_errors++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    summarize();
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang("pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK("pslverr", 1'b0, err)
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("pslverr", 1'b0, err)
    `CHK(nm, e, rd & m)
  endtask : rd_chk

  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq_valid !== lvl && n < 60);
    if (n >= 60) hang("irq_valid");
  endtask : wait_valid

  task automatic vec(input logic [20:0] l, input logic [4:0] en, input logic [15:0] ea);
    irq_lines <= l;
    wait_valid(1'b1);
    `CHK("irq_num", en, irq_num)
    `CHK("irq_addr", ea, irq_addr)
    irq_lines <= 21'h0;
    wait_valid(1'b0);
  endtask : vec

  task automatic sweep(input logic [15:0] base);
    for (int i = 0; i < NUM_SRC; i++) begin
      vec(21'h1 << i, 5'(i + 2), base + 16'(2 * (i + 1)));
    end
  endtask : sweep

  task automatic do_reset(input logic f, input logic [15:0] exp);
    int n;
    nrst <= 1'b0;
    fuse <= f;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reset_fetch !== 1'b1 && n < 20);
    if (n >= 20) hang("reset_fetch");
    `CHK("reset_addr", exp, reset_addr)
  endtask : do_reset

  initial begin
    nrst = 1'b0;
    fuse = 1'b1;
    gie = 1'b1;
    insn_go = 1'b0;
    ack_wait = 4'h0;
    irq_lines = 21'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    tests_run = 0;
    do_reset(1'b1, 16'h0000);
    rd_chk("mask", REG_MASK, 32'hffffffff, 32'h0);
    rd_chk("state", REG_STATE, 32'hf, 32'h0);
    sweep(16'h0000);
    ack_wait <= 4'h7;
    vec(21'h100a00, 5'h0b, 16'h0014);
    vec(21'h1fffff, 5'h02, 16'h0002);
    ack_wait <= 4'hf;
    irq_lines <= 21'h4;
    wait_valid(1'b1);
    rd_chk("state", REG_STATE, 32'h1f10, 32'h0410);
    irq_lines <= 21'h0;
    wait_valid(1'b0);
    ack_wait <= 4'h0;
    gie <= 1'b0;
    irq_lines <= 21'h1;
    repeat (5) @(posedge clk);
    `CHK("irq_valid", 1'b0, irq_valid)
    gie <= 1'b1;
    irq_lines <= 21'h0;
    wr(REG_MASK, 32'h3);
    rd_chk("mask", REG_MASK, 32'hffffffff, 32'h3);
    wr(REG_CTRL, 32'h1);
    wr(REG_CTRL, 32'h2);
    rd_chk("state", REG_STATE, 32'hf, 32'h9);
    irq_lines <= 21'h1;
    repeat (4) @(posedge clk);
    `CHK("blocked", 1'b1, accept_blocked)
    `CHK("irq_valid", 1'b0, irq_valid)
    `CHK("intr", 1'b1, intr)
    rd_chk("status", REG_STATUS, 32'hffffffff, 32'h1);
    rd_chk("status", REG_STATUS, 32'hffffffff, 32'h0);
    `CHK("intr", 1'b0, intr)
    irq_lines <= 21'h0;
    insn_go <= 1'b1;
    repeat (3) @(posedge clk);
    insn_go <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("blocked", 1'b0, accept_blocked)
    sweep(BOOT);
    wr(REG_CTRL, 32'h1);
    @(posedge clk);
    `CHK("blocked", 1'b1, accept_blocked)
    repeat (6) @(posedge clk);
    `CHK("blocked", 1'b0, accept_blocked)
    rd_chk("state", REG_STATE, 32'hf, 32'h1);
    rd_chk("status", REG_STATUS, 32'hffffffff, 32'h2);
    wr(REG_CTRL, 32'h0);
    rd_chk("ctrl", REG_CTRL, 32'h3, 32'h2);
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    `CHK("intr", 1'b0, intr)
    rd_chk("status", REG_STATUS, 32'hffffffff, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pslverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    apb(1'b1, 8'h20, 32'hffffffff);
    `CHK("pslverr", 1'b1, err)
    do_reset(1'b0, BOOT);
    rd_chk("state", REG_STATE, 32'hf, 32'h2);
    rd_chk("mask", REG_MASK, 32'hffffffff, 32'h0);
    vec(21'h2, 5'h03, 16'h0004);
    summarize();
  end
endmodule : vector_map_test
